// ---- src/acr_pkg.sv ----
// Package with register map, field layout, reset values and timing constants of the control bank.
package acr_pkg;

   // Register indices; the byte address on the bus is four times the index.
   localparam logic [5:0]  IDX_FMT        = 6'h00;
   localparam logic [5:0]  IDX_GAIN       = 6'h01;
   localparam logic [5:0]  IDX_DAC        = 6'h02;
   localparam logic [5:0]  IDX_RSVD       = 6'h0E;

   // Field positions in the format and rate register.
   localparam int          HPF_LSB        = 14;
   localparam int          WORD_LENGTH_SELECT_LSB       = 10;
   localparam int          FMT_LSB        = 8;
   localparam int          DACDIV_LSB     = 3;
   localparam int          ADCDIV_LSB     = 0;

   // Field positions in the headset gain register.
   localparam int          HSMUTE_BIT     = 15;
   localparam int          HSGAIN_LSB     = 8;
   localparam int          TARGET_LSB     = 5;
   localparam int          TC_LSB         = 1;
   localparam int          AGCEN_BIT      = 0;

   // Field positions in the DAC volume register.
   localparam int          LMUTE_BIT      = 15;
   localparam int          LVOL_LSB       = 8;
   localparam int          RMUTE_BIT      = 7;
   localparam int          RVOL_LSB       = 0;

   // Reset values and writable masks.
   localparam logic [15:0] FMT_RST        = 16'h0000;
   localparam logic [15:0] FMT_WMASK      = 16'hCF3F;
   localparam logic [15:0] GAIN_RST       = 16'hFF00;
   localparam logic [15:0] DAC_RST        = 16'hFFFF;
   localparam logic [15:0] RSVD_RST       = 16'hFF00;
   localparam logic [15:0] RSVD_WMASK     = 16'hFF00;
   localparam logic [6:0]  GAIN_MAX       = 7'h7F;

   // Clock rate and the millisecond time base derived from it.
   localparam int          CLK_FREQ_KHZ   = 200000;
   localparam int          TIME_BASE_MS   = 1;
   localparam int          MS_CYCLES      = CLK_FREQ_KHZ * TIME_BASE_MS;

   // Gain loop attack and decay times in milliseconds.
   localparam int          ATTACK_MS [4]  = '{8, 11, 16, 20};
   localparam int          DECAY_MS  [4]  = '{100, 200, 400, 500};

   // Gain loop targets as attenuation below full scale, in half-dB units.
   localparam int          TARGET_HDB [8] = '{11, 16, 20, 24, 28, 34, 40, 48};

   // Rate divisors expressed in ticks of a twice-reference-rate strobe.
   localparam int          RATE_HALF [8]  = '{2, 3, 4, 6, 8, 10, 11, 12};

   // Settings handed to the audio datapath.
   typedef struct packed {
      logic [1:0] hpf;
      logic [1:0] word_length_select;
      logic [1:0] fmt;
      logic [2:0] dac_div;
      logic [2:0] adc_div;
      logic [2:0] target;
      logic [3:0] tc;
      logic       agc_en;
      logic       l_mute;
      logic [6:0] l_vol;
      logic       r_mute;
      logic [6:0] r_vol;
   } acr_ctrl_t;

endpackage : acr_pkg

// ---- src/acr_rate_div.sv ----
// Fractional sample-rate divider producing a one-cycle sample strobe.
`timescale 1ns/1ps
module acr_rate_div (
   input  wire logic       clk,
   input  wire logic       rst_b,
   input  wire logic       tick2x,
   input  wire logic [2:0] code,
   output logic            sample_tick
);

   logic [3:0] cnt_q;
   logic       tick_q;
   wire  [3:0] last = 4'(acr_pkg::RATE_HALF[code] - 1);
   wire        wrap = tick2x & (cnt_q >= last);

   // Counting half periods of the reference lets 1.5 and 5.5 come out exact on average.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_q  <= 4'h0;
         tick_q <= 1'b0;
      end else begin
         tick_q <= wrap;
         if (wrap) begin
            cnt_q <= 4'h0;
         end else if (tick2x) begin
            cnt_q <= cnt_q + 4'h1;
         end
      end
   end

   assign sample_tick = tick_q;

   chk_tick_needs_strobe: assert property (@(posedge clk) disable iff (!rst_b)
      tick_q |-> $past(tick2x)) else $error("sample strobe without reference strobe");

endmodule : acr_rate_div

// ---- src/acr_agc.sv ----
// Automatic gain loop stepping the headset gain toward the target level.
`timescale 1ns/1ps
module acr_agc (
   input  wire logic       clk,
   input  wire logic       rst_b,
   input  wire logic       en,
   input  wire logic       ms_tick,
   input  wire logic [2:0] target,
   input  wire logic [3:0] tc,
   input  wire logic [6:0] level_attn,
   input  wire logic       level_valid,
   input  wire logic [6:0] load_gain,
   output logic [6:0]      gain
);

   logic [8:0] cnt_q;
   logic [6:0] gain_q;
   logic       loud_q;
   logic       quiet_q;
   wire  [6:0] tgt     = 7'(acr_pkg::TARGET_HDB[target]);
   wire  [8:0] att_end = 9'(acr_pkg::ATTACK_MS[tc[1:0]] - 1);
   wire  [8:0] dec_end = 9'(acr_pkg::DECAY_MS[tc[3:2]] - 1);
   wire  [8:0] lim     = loud_q ? att_end : dec_end;
   wire        step    = ms_tick & (loud_q | quiet_q) & (cnt_q >= lim);

   // Level is latched per sample so the loop sees a steady verdict between ms ticks.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         loud_q  <= 1'b0;
         quiet_q <= 1'b0;
      end else if (level_valid) begin
         loud_q  <= level_attn < tgt;
         quiet_q <= level_attn > tgt;
      end
   end

   // Times are in wall-clock ms, so they do not move with the sample rate.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_q  <= 9'h000;
         gain_q <= acr_pkg::GAIN_MAX;
      end else if (!en) begin
         cnt_q  <= 9'h000;
         gain_q <= load_gain;
      end else if (step) begin
         cnt_q <= 9'h000;
         if (loud_q && gain_q != 7'h00) begin
            gain_q <= gain_q - 7'h01;
         end else if (quiet_q && gain_q != acr_pkg::GAIN_MAX) begin
            gain_q <= gain_q + 7'h01;
         end
      end else if (ms_tick) begin
         cnt_q <= (loud_q | quiet_q) ? cnt_q + 9'h001 : 9'h000;
      end
   end

   assign gain = gain_q;

   chk_gain_fall_loud: assert property (@(posedge clk) disable iff (!rst_b)
      (en && $past(en) && gain_q < $past(gain_q)) |-> $past(loud_q) && $past(ms_tick))
      else $error("gain fell without a loud verdict");

   chk_gain_rise_quiet: assert property (@(posedge clk) disable iff (!rst_b)
      (en && $past(en) && gain_q > $past(gain_q)) |-> $past(quiet_q) && $past(ms_tick))
      else $error("gain rose without a quiet verdict");

endmodule : acr_agc

// ---- src/acr_regs.sv ----
// APB register bank holding audio format, rate, headset gain and DAC volume controls.
//
// Contract
// - Bits 15:14 pick the ADC high-pass corner, or off at zero.
// - Bits 11:10 pick a 16, 20, 24 or 32-bit word, default 16.
// - Bits 9:8 pick I2S, DSP, right or left justified, default I2S.
// - Bits 5:3 divide the reference rate for the DAC sample strobe.
// - Bits 2:0 divide the reference rate for the ADC strobe, default one.
// - Headset mute bit 15 mutes the input and resets set.
// - Headset gain bits 14:8 give half-dB gain steps, reset all ones.
// - With the gain loop on and headset selected, reads return the applied gain.
// - Bits 7:5 pick the target output level of the gain loop.
// - Bits 4:1 pick attack and decay times in fixed milliseconds.
// - Bit 0 hands the gain stage to the loop; else software fields rule.
// - DAC bit 15 mutes the left channel and resets set.
// - DAC bits 14:8 set left attenuation in half-dB steps, reset maximum.
// - DAC bit 7 mutes the right channel and resets set.
// - DAC bits 6:0 set right attenuation in half-dB steps, reset maximum.
`timescale 1ns/1ps
module acr_regs #(
   parameter int MS_CYCLES = acr_pkg::MS_CYCLES
) (
   input  wire logic              clk,
   input  wire logic              rst_b,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [31:0]       pwdata,
   input  wire logic [3:0]        pstrb,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              fsref2x_tick,
   input  wire logic              headset_selected,
   input  wire logic [6:0]        adc_level_attn,
   input  wire logic              adc_level_valid,
   output acr_pkg::acr_ctrl_t     ctrl,
   output logic                   pga_mute,
   output logic [6:0]             pga_gain,
   output logic                   dac_sample_tick,
   output logic                   adc_sample_tick
);

   localparam int MS_W = $clog2(MS_CYCLES + 1);

   logic [15:0]     fmt_q;
   logic [15:0]     gain_q;
   logic [15:0]     dac_q;
   logic [15:0]     rsvd_q;
   logic [31:0]     prdata_q;
   logic            pready_q;
   logic            pslverr_q;
   logic            pga_mute_q;
   logic [6:0]      pga_gain_q;
   logic [MS_W-1:0] ms_cnt_q;
   logic            ms_tick_q;
   logic [6:0]      agc_gain;

   // Bus phase decode; a write lands only on the completing access edge.
   wire        setup   = psel & ~penable;
   wire        done    = psel & penable & pready_q;
   wire        wr      = done & pwrite;
   wire [5:0]  idx     = paddr[7:2];
   wire        aligned = paddr[1:0] == 2'b00;
   wire        hit_fmt = aligned & (idx == acr_pkg::IDX_FMT);
   wire        hit_gn  = aligned & (idx == acr_pkg::IDX_GAIN);
   wire        hit_dac = aligned & (idx == acr_pkg::IDX_DAC);
   wire        hit_rsv = aligned & (idx == acr_pkg::IDX_RSVD);
   wire        mapped  = hit_fmt | hit_gn | hit_dac | hit_rsv;

   // Byte lanes 0 and 1 carry the 16-bit registers; upper lanes are ignored.
   wire [15:0] lane_m  = {{8{pstrb[1]}}, {8{pstrb[0]}}};
   wire [15:0] fmt_m   = lane_m & acr_pkg::FMT_WMASK;
   wire [15:0] rsv_m   = lane_m & acr_pkg::RSVD_WMASK;
   wire [15:0] fmt_d   = (fmt_q & ~fmt_m) | (pwdata[15:0] & fmt_m);
   wire [15:0] gain_d  = (gain_q & ~lane_m) | (pwdata[15:0] & lane_m);
   wire [15:0] dac_d   = (dac_q & ~lane_m) | (pwdata[15:0] & lane_m);
   // Any value is stored; keeping the byte all-ones is left to software.
   wire [15:0] rsvd_d  = (rsvd_q & ~rsv_m) | (pwdata[15:0] & rsv_m);

   // Applied-gain view replaces the software fields on read while the loop runs and the headset is selected.
   wire        agc_on    = gain_q[acr_pkg::AGCEN_BIT];
   wire        agc_view  = agc_on & headset_selected;
   wire [15:0] gain_rd   = agc_view ? {pga_mute_q, pga_gain_q, gain_q[7:0]} : gain_q;
   wire [15:0] rd_mux    = hit_fmt ? fmt_q :
                           hit_gn  ? gain_rd :
                           hit_dac ? dac_q :
                           hit_rsv ? rsvd_q : 16'h0000;

   // Gain stage source: the loop when enabled, the software fields otherwise.
   wire        pga_mute_d = agc_on ? 1'b0 : gain_q[acr_pkg::HSMUTE_BIT];
   wire [6:0]  pga_gain_d = agc_on ? agc_gain
                                   : gain_q[acr_pkg::HSGAIN_LSB +: 7];

   // Register storage; the reset values start every mute engaged.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         fmt_q  <= acr_pkg::FMT_RST;
         gain_q <= acr_pkg::GAIN_RST;
         dac_q  <= acr_pkg::DAC_RST;
         rsvd_q <= acr_pkg::RSVD_RST;
      end else if (wr) begin
         if (hit_fmt) begin
            fmt_q <= fmt_d;
         end
         if (hit_gn) begin
            gain_q <= gain_d;
         end
         if (hit_dac) begin
            dac_q <= dac_d;
         end
         if (hit_rsv) begin
            rsvd_q <= rsvd_d;
         end
      end
   end

   // Read data and the answer are prepared in setup, giving zero wait states.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         prdata_q  <= 32'h0000_0000;
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         pready_q  <= setup;
         pslverr_q <= setup & ~mapped;
         if (setup) begin
            prdata_q <= {16'h0000, rd_mux};
         end
      end
   end

   // Applied gain is registered so the analog stage never sees a decode glitch.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pga_mute_q <= 1'b1;
         pga_gain_q <= acr_pkg::GAIN_MAX;
      end else begin
         pga_mute_q <= pga_mute_d;
         pga_gain_q <= pga_gain_d;
      end
   end

   // Millisecond time base for the gain loop, independent of audio rates.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ms_cnt_q  <= '0;
         ms_tick_q <= 1'b0;
      end else if (ms_cnt_q == MS_W'(MS_CYCLES - 1)) begin
         ms_cnt_q  <= '0;
         ms_tick_q <= 1'b1;
      end else begin
         ms_cnt_q  <= ms_cnt_q + MS_W'(1);
         ms_tick_q <= 1'b0;
      end
   end

   acr_agc u_agc (
      .clk         (clk),
      .rst_b       (rst_b),
      .en          (agc_on),
      .ms_tick     (ms_tick_q),
      .target      (gain_q[acr_pkg::TARGET_LSB +: 3]),
      .tc          (gain_q[acr_pkg::TC_LSB +: 4]),
      .level_attn  (adc_level_attn),
      .level_valid (adc_level_valid),
      .load_gain   (gain_q[acr_pkg::HSGAIN_LSB +: 7]),
      .gain        (agc_gain)
   );

   acr_rate_div u_dac_div (
      .clk         (clk),
      .rst_b       (rst_b),
      .tick2x      (fsref2x_tick),
      .code        (fmt_q[acr_pkg::DACDIV_LSB +: 3]),
      .sample_tick (dac_sample_tick)
   );

   acr_rate_div u_adc_div (
      .clk         (clk),
      .rst_b       (rst_b),
      .tick2x      (fsref2x_tick),
      .code        (fmt_q[acr_pkg::ADCDIV_LSB +: 3]),
      .sample_tick (adc_sample_tick)
   );

   // Settings fan out straight from the register flops.
   assign ctrl.hpf     = fmt_q[acr_pkg::HPF_LSB +: 2];
   assign ctrl.word_length_select    = fmt_q[acr_pkg::WORD_LENGTH_SELECT_LSB +: 2];
   assign ctrl.fmt     = fmt_q[acr_pkg::FMT_LSB +: 2];
   assign ctrl.dac_div = fmt_q[acr_pkg::DACDIV_LSB +: 3];
   assign ctrl.adc_div = fmt_q[acr_pkg::ADCDIV_LSB +: 3];
   assign ctrl.target  = gain_q[acr_pkg::TARGET_LSB +: 3];
   assign ctrl.tc      = gain_q[acr_pkg::TC_LSB +: 4];
   assign ctrl.agc_en  = gain_q[acr_pkg::AGCEN_BIT];
   assign ctrl.l_mute  = dac_q[acr_pkg::LMUTE_BIT];
   assign ctrl.l_vol   = dac_q[acr_pkg::LVOL_LSB +: 7];
   assign ctrl.r_mute  = dac_q[acr_pkg::RMUTE_BIT];
   assign ctrl.r_vol   = dac_q[acr_pkg::RVOL_LSB +: 7];

   // Bus and gain outputs.
   assign prdata   = prdata_q;
   assign pready   = pready_q;
   assign pslverr  = pslverr_q;
   assign pga_mute = pga_mute_q;
   assign pga_gain = pga_gain_q;

   // Write of the format register and its effect on the next cycle.
   sequence s_fmt_write;
      wr && hit_fmt && pstrb[1] && pstrb[0];
   endsequence

   chk_hpf_follow_write: assert property (@(posedge clk) disable iff (!rst_b)
      s_fmt_write |=> ctrl.hpf == $past(pwdata[15:14])) else $error("hpf field not written");

   chk_word_length_select_follow_write: assert property (@(posedge clk) disable iff (!rst_b)
      s_fmt_write |=> ctrl.word_length_select == $past(pwdata[11:10])) else $error("word length not written");

   chk_fmt_follow_write: assert property (@(posedge clk) disable iff (!rst_b)
      s_fmt_write |=> ctrl.fmt == $past(pwdata[9:8])) else $error("format not written");

   chk_rates_follow_write: assert property (@(posedge clk) disable iff (!rst_b)
      s_fmt_write |=> {ctrl.dac_div, ctrl.adc_div} == $past(pwdata[5:0]))
      else $error("rate divisors not written");

   chk_reserved_read_zero: assert property (@(posedge clk) disable iff (!rst_b)
      (setup && hit_fmt) |=> prdata_q[13:12] == 2'b00 && prdata_q[7:6] == 2'b00
                             && prdata_q[31:16] == 16'h0000) else $error("reserved bits read set");

   chk_agc_readback: assert property (@(posedge clk) disable iff (!rst_b)
      (setup && hit_gn && agc_view) |=> prdata_q[15:8] == $past({pga_mute_q, pga_gain_q}))
      else $error("read does not show applied gain");

   chk_manual_gain_path: assert property (@(posedge clk) disable iff (!rst_b)
      (!agc_on [*2]) |-> pga_gain_q == $past(gain_q[14:8]) && pga_mute_q == $past(gain_q[15]))
      else $error("gain stage ignores software fields");

   chk_mutes_after_reset: assert property (@(posedge clk)
      (rst_b && !$past(rst_b)) |-> gain_q[15] && ctrl.l_mute && ctrl.r_mute && pga_mute_q)
      else $error("mute not set after reset");

   chk_volume_write: assert property (@(posedge clk) disable iff (!rst_b)
      (wr && hit_dac && pstrb[1] && pstrb[0])
      |=> {ctrl.l_mute, ctrl.l_vol, ctrl.r_mute, ctrl.r_vol} == $past(pwdata[15:0]))
      else $error("volume register not written");

   chk_unmapped_error: assert property (@(posedge clk) disable iff (!rst_b)
      (setup && !mapped) |=> pready_q && pslverr_q && $past(rd_mux) == 16'h0000)
      else $error("unmapped access not flagged");

   // An unmapped write must leave every register untouched.
   chk_unmapped_no_write: assert property (@(posedge clk) disable iff (!rst_b)
      (wr && !mapped)
      |=> $stable(fmt_q) && $stable(gain_q) && $stable(dac_q) && $stable(rsvd_q))
      else $error("unmapped write changed a register");

   // The answer comes in the first access cycle, and an error never comes alone.
   chk_ready_after_setup: assert property (@(posedge clk) disable iff (!rst_b)
      setup |=> pready_q) else $error("no ready after setup");

   chk_error_needs_ready: assert property (@(posedge clk) disable iff (!rst_b)
      pslverr_q |-> pready_q) else $error("error flag without ready");

   // First edge with the reset input high again.
   sequence s_reset_release;
      rst_b && !$past(rst_b);
   endsequence

   // Volumes and the headset gain start at their all-ones codes.
   chk_volume_reset: assert property (@(posedge clk)
      s_reset_release |-> ctrl.l_vol == acr_pkg::GAIN_MAX && ctrl.r_vol == acr_pkg::GAIN_MAX)
      else $error("volume not at full attenuation after reset");

   chk_gain_reset: assert property (@(posedge clk)
      s_reset_release |-> gain_q[14:8] == acr_pkg::GAIN_MAX && pga_gain_q == acr_pkg::GAIN_MAX)
      else $error("headset gain not all ones after reset");

   // A full-word gain write lands unchanged in the register.
   chk_gain_write: assert property (@(posedge clk) disable iff (!rst_b)
      (wr && hit_gn && pstrb[1] && pstrb[0]) |=> gain_q == $past(pwdata[15:0]))
      else $error("gain register not written");

   // The fill byte keeps what software wrote; its low byte stays zero.
   chk_fill_write: assert property (@(posedge clk) disable iff (!rst_b)
      (wr && hit_rsv && pstrb[1])
      |=> rsvd_q[15:8] == $past(pwdata[15:8]) && rsvd_q[7:0] == 8'h00)
      else $error("fill register not written");

   // While the loop runs, the gain stage is unmuted and follows the loop gain.
   chk_loop_unmutes: assert property (@(posedge clk) disable iff (!rst_b)
      agc_on |=> !pga_mute_q) else $error("gain stage muted while loop runs");

   chk_loop_gain_path: assert property (@(posedge clk) disable iff (!rst_b)
      agc_on |=> pga_gain_q == $past(agc_gain)) else $error("gain stage ignores loop gain");

endmodule : acr_regs

// ---- test/acr_regs_tb.sv ----
// Self-checking testbench for the audio control register bank.
`timescale 1ns/1ps
module acr_regs_tb;
   localparam int      MS = 20;
   logic               clk, rst_b, psel, penable, pwrite, fs2x, hs_sel, lvl_valid, err;
   logic [7:0]         paddr;
   logic [31:0]        pwdata, prdata, rd;
   logic [3:0]         pstrb;
   logic               pready, pslverr, pga_mute, dac_tick, adc_tick;
   logic [6:0]         lvl_attn, pga_gain, eg;
   acr_pkg::acr_ctrl_t ctrl;
   logic [15:0]        m [4];
   logic [15:0]        wd;
   logic [15:0]        wmask [4] = '{16'hCF3F, 16'hFFFF, 16'hFFFF, 16'hFF00};
   logic [7:0]         addr_of [4] = '{{acr_pkg::IDX_FMT, 2'b00}, {acr_pkg::IDX_GAIN, 2'b00},
                                       {acr_pkg::IDX_DAC, 2'b00}, {acr_pkg::IDX_RSVD, 2'b00}};
   logic [7:0]         bad [5] = '{8'h0C, 8'h3C, 8'h01, 8'h06, 8'hFC};
   int                 half_div [8] = '{2, 3, 4, 6, 8, 10, 11, 12};
   int                 atk_ms [4] = '{8, 11, 16, 20};
   int                 dec_ms [4] = '{100, 200, 400, 500};
   int                 mismatches, check_count, fs_cnt, sc, r;
   integer             seed;

   acr_regs #(.MS_CYCLES(MS)) uut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .fsref2x_tick(fs2x), .headset_selected(hs_sel),
      .adc_level_attn(lvl_attn), .adc_level_valid(lvl_valid), .ctrl(ctrl),
      .pga_mute(pga_mute), .pga_gain(pga_gain), .dac_sample_tick(dac_tick),
      .adc_sample_tick(adc_tick));

   // Free-running 200 MHz clock.
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // Twice-reference strobe every third cycle; every strobe sent is counted for the gap checks.
   always @(posedge clk) begin
      fs2x   <= (fs_cnt % 3 == 2);
      fs_cnt <= fs_cnt + 1;
      sc     <= sc + int'(fs2x);
   end

   // Prints the counts and the verdict, then stops the run.
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : end_of_test

   // A wait that ran out of its bound is a mismatch and ends the run.
   task automatic timeout();
      mismatches++;
      $display("[ERR] handshake expected within bound, seen none");
      end_of_test();
   endtask : timeout

   // Compares one 16-bit result with its expected value.
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   // One APB transfer; the request is held until pready is seen high at a rising edge.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [15:0] d,
                      input logic [3:0] st);
      int n;
      n = 0;
      @(posedge clk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= {16'($random(seed)), d};
      pstrb   <= st;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) begin
         n++;
         if (n > 16) timeout();
         @(posedge clk);
      end
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Expected field view of the format register.
   function automatic logic [15:0] fmt_view(input logic [15:0] v);
      return {4'h0, v[15:14], v[11:8], v[5:0]};
   endfunction : fmt_view

   // Expected gain stage: the loop's gain, unmuted, while it runs; else the software fields.
   function automatic logic [15:0] pga_view(input logic [15:0] v);
      return {8'h00, v[0] ? {1'b0, eg} : v[15:8]};
   endfunction : pga_view

   // Reads a register back and checks it and the outputs that it drives.
   task automatic rd_chk(input int i);
      logic [15:0] fs, gc, pg, dv;
      apb(1'b0, addr_of[i], 16'h0000, 4'h0);
      fs = {4'h0, ctrl.hpf, ctrl.word_length_select, ctrl.fmt, ctrl.dac_div, ctrl.adc_div};
      gc = {8'h00, ctrl.target, ctrl.tc, ctrl.agc_en};
      pg = {8'h00, pga_mute, pga_gain};
      dv = {ctrl.l_mute, ctrl.l_vol, ctrl.r_mute, ctrl.r_vol};
      chk("readback", m[i], rd[15:0]);
      chk("read_upper", 16'h0000, rd[31:16]);
      chk("read_err", 16'h0000, {15'h0000, err});
      if (i == 0) chk("fmt_fields", fmt_view(m[0]), fs);
      if (i == 1) chk("gain_ctl", {8'h00, m[1][7:0]}, gc);
      if (i == 1) chk("pga", pga_view(m[1]), pg);
      if (i == 2) chk("dac", m[2], dv);
   endtask : rd_chk

   // Writes with byte strobes, updates the bench's copy and reads back.
   task automatic wr_chk(input int i, input logic [15:0] d, input logic [3:0] st);
      m[i] = {st[1] ? d[15:8] : m[i][15:8], st[0] ? d[7:0] : m[i][7:0]} & wmask[i];
      apb(1'b1, addr_of[i], d, st);
      rd_chk(i);
   endtask : wr_chk

   // Measures strobes between two sample ticks; the gap must equal twice the divisor.
   task automatic tick_gap(input logic dac, input int h);
      int n, s0;
      n = 0;
      for (int i = 0; i < 2; i++) begin
         s0 = sc;
         do begin
            @(posedge clk);
            n++;
         end while ((dac ? dac_tick : adc_tick) !== 1'b1 && n < 200);
      end
      if (n >= 200) timeout();
      chk(dac ? "dac_gap" : "adc_gap", 16'(h), 16'(sc - s0));
   endtask : tick_gap

   // Waits for two loop gain steps and checks their direction and spacing.
   task automatic step(input int cyc, input logic up);
      int n;
      logic [6:0] g;
      n = 0;
      for (int i = 0; i < 2; i++) begin
         g = pga_gain;
         n = 0;
         do begin
            @(posedge clk);
            n++;
         end while (pga_gain === g && n < 2 * cyc + 50);
         if (pga_gain === g) timeout();
         eg = up ? eg + 7'h01 : eg - 7'h01;
         chk("loop_gain", {9'h000, eg}, {9'h000, pga_gain});
      end
      chk("step_time", 16'h0001, {15'h0000, n >= cyc - 2 && n <= cyc + 2});
   endtask : step

   // Raises the level strobe for one cycle with the given attenuation.
   task automatic level(input logic [6:0] a);
      @(posedge clk);
      lvl_attn  <= a;
      lvl_valid <= 1'b1;
      @(posedge clk);
      lvl_valid <= 1'b0;
   endtask : level

   // Main sequence: reset, every rate and format code, random traffic, refusals, then the gain loop.
   initial begin
      seed = 32'h88F76D8D;
      {psel, penable, pwrite, hs_sel, lvl_valid} = 5'h00;
      {paddr, pwdata, pstrb, lvl_attn} = '0;
      {mismatches, check_count} = '0;
      m = '{16'h0000, 16'hFF00, 16'hFFFF, 16'hFF00};
      eg = 7'h7F;
      rst_b = 1'b0;
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      for (int i = 0; i < 4; i++) rd_chk(i);
      $display("test reset_values done");
      // Equal rates keep right-justified framing legal for code 2.
      for (int k = 0; k < 8; k++) begin
         wd = {k[1:0], 2'b11, k[1:0], k[1:0], 2'b11, k[2:0], k[2:0]};
         wr_chk(0, wd, 4'h3);
         tick_gap(1'b1, half_div[k]);
         tick_gap(1'b0, half_div[k]);
      end
      $display("test codes_and_rates done");
      for (int k = 0; k < 40; k++) begin
         r = {$random(seed)} % 3;
         wd = 16'($random(seed));
         wd[0] = (r == 1) ? 1'b0 : wd[0];
         if (r == 0 && wd[9:8] == 2'b10) wd[2:0] = wd[5:3];
         wr_chk(r, wd, (r == 0) ? 4'h3 : 4'($random(seed)));
      end
      wr_chk(3, {8'hFF, 8'($random(seed))}, 4'h3);
      $display("test random_access done");
      foreach (bad[i]) begin
         apb(1'b1, bad[i], 16'($random(seed)), 4'h3);
         chk("err_wr", 16'h0001, {15'h0000, err});
         apb(1'b0, bad[i], 16'h0000, 4'h0);
         chk("err_rd", 16'h0001, {15'h0000, err});
         chk("err_data", 16'h0000, rd[15:0]);
      end
      for (int i = 0; i < 4; i++) rd_chk(i);
      $display("test refusals done");
      eg = 7'h40;
      wr_chk(1, 16'hC000, 4'h3);
      wr_chk(1, 16'h0001, 4'h1);
      level(7'h00);
      for (int t = 0; t < 4; t++) begin
         wr_chk(1, {8'h00, 3'b000, 4'(t), 1'b1}, 4'h1);
         step(atk_ms[t] * MS, 1'b0);
      end
      hs_sel <= 1'b1;
      apb(1'b0, addr_of[1], 16'h0000, 4'h0);
      chk("loop_view", {8'h00, 1'b0, eg}, {8'h00, rd[15:8]});
      hs_sel <= 1'b0;
      apb(1'b0, addr_of[1], 16'h0000, 4'h0);
      chk("sw_view", {8'h00, m[1][15:8]}, {8'h00, rd[15:8]});
      level(7'h7F);
      for (int t = 0; t < 4; t++) begin
         wr_chk(1, {8'h00, 3'b000, 2'(t), 2'b00, 1'b1}, 4'h1);
         step(dec_ms[t] * MS, 1'b1);
      end
      $display("test gain_loop done");
      end_of_test();
   end
endmodule : acr_regs_tb
